// ### rtl/scl_pkg.sv
package scl_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ     = 250;
    localparam int unsigned SK_HALF_NS  = 40;
    localparam int unsigned SK_HALF_CYC = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  TICK_LAST   = 4'(SK_HALF_CYC - 1);

    // ------------------------------------------------------------
    // serial word read command
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W     = 6;
    localparam logic [2:0]  RD_OPCODE  = 3'h6;
    localparam logic [4:0]  SLOT_DATA0 = 5'h09;
    localparam logic [4:0]  SLOT_LAST  = 5'h18;
    localparam logic [7:0]  ADDR_LAST  = 8'h3f;

    // ------------------------------------------------------------
    // image layout
    // ------------------------------------------------------------
    // signature value is arbitrary
    localparam logic [11:0] HDR_SIG     = 12'h5a3;
    localparam int unsigned HDR_SIG_LSB = 4;
    localparam int unsigned MORE_BIT    = 15;
    localparam logic [15:0] Z3_HDR_WORD = 16'h8001;
    localparam logic [15:0] Z3_END_WORD = 16'h0000;
    localparam logic [6:0]  ID_SEL_LAST = 7'h03;

    localparam logic [2:0] ZONE_HDR   = 3'h0;
    localparam logic [2:0] ZONE_LOCAL = 3'h1;
    localparam logic [2:0] ZONE_ID    = 3'h2;
    localparam logic [2:0] ZONE_PCI   = 3'h3;
    localparam logic [2:0] ZONE_END   = 3'h4;

    localparam logic [1:0] Z3_PH_HDR  = 2'h0;
    localparam logic [1:0] Z3_PH_DATA = 2'h1;
    localparam logic [1:0] Z3_PH_TAIL = 2'h3;

    // write target spaces
    localparam logic [1:0] SPACE_LOCAL = 2'h1;
    localparam logic [1:0] SPACE_ID    = 2'h2;
    localparam logic [1:0] SPACE_PCI   = 2'h3;

    // ------------------------------------------------------------
    // local configuration register byte offsets
    // ------------------------------------------------------------
    localparam logic [6:0] OFS_LOCAL_CONFIG_CONTROL = 7'h00;
    localparam logic [6:0] OFS_MULTIPURPOSE_IO      = 7'h04;
    localparam logic [6:0] OFS_BUS_TIMING_ONE       = 7'h08;
    localparam logic [6:0] OFS_BUS_TIMING_TWO       = 7'h0c;
    localparam logic [6:0] OFS_TIMING_TWO_B2        = 7'h0e;
    localparam logic [6:0] OFS_TIMING_TWO_B3        = 7'h0f;
    localparam logic [6:0] OFS_INT_MASK_B2          = 7'h1e;
    localparam logic [6:0] OFS_INT_MASK_B3          = 7'h1f;
    localparam int unsigned LCC_RELOAD_BIT          = 29;
    localparam int unsigned LCC_VALID_BIT           = 28;

    // must-be-zero masks for the control byte and timing two bytes 2 and 3
    localparam logic [7:0] MBZ_LCC_B0 = 8'h03;
    localparam logic [7:0] MBZ_LT2_B2 = 8'h0f;
    localparam logic [7:0] MBZ_LT2_B3 = 8'h20;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_SHIFT = 2'b01,
        RD_GAP   = 2'b11
    } scl_rd_e;

    typedef enum logic [2:0] {
        LD_REQ    = 3'b000,
        LD_WAIT   = 3'b001,
        LD_DECODE = 3'b011,
        LD_DONE   = 3'b010
    } scl_ld_e;

    // next present zone after cur, or ZONE_END
    function automatic logic [2:0] scl_next_zone(input logic [2:0] cur,
                                                 input logic [2:0] fl);
        logic [2:0] r;
        r = ZONE_END;
        for (int z = 3; z >= 1; z--) begin
            if (3'(z) > cur && fl[3-z]) begin
                r = 3'(z);
            end
        end
        return r;
    endfunction

    // clears must-be-zero fields of a local register byte
    function automatic logic [7:0] scl_mask_byte(input logic [6:0] ofs,
                                                 input logic [7:0] d);
        logic [7:0] m;
        m = 8'h00;
        case (ofs)
            OFS_LOCAL_CONFIG_CONTROL: m = MBZ_LCC_B0;
            OFS_TIMING_TWO_B2:        m = MBZ_LT2_B2;
            OFS_TIMING_TWO_B3:        m = MBZ_LT2_B3;
            default:                  m = 8'h00;
        endcase
        return d & ~m;
    endfunction

endpackage

// ### rtl/scl_rd_if.sv
`timescale 1ns/1ns
`default_nettype none
interface scl_rd_if;
    logic        req;
    logic        busy;
    logic        done;
    logic [7:0]  addr;
    logic [15:0] word;

    modport loader (output req, output addr, input busy, input done,
                    input word);
    modport reader (input req, input addr, output busy, output done,
                    output word);
endinterface
`default_nettype wire

// ### rtl/scl_word_rd.sv
`timescale 1ns/1ns
`default_nettype none
module scl_word_rd
    import scl_pkg::*;
(
    input  wire logic    core_clk_i,
    input  wire logic    rst_n_i,
    input  wire logic    ee_data_in_i,
    output logic         ee_clk_o,
    output logic         ee_sel_o,
    output logic         ee_data_out_o,
    scl_rd_if.reader     rd
);

    typedef struct packed {
        scl_rd_e     st;
        logic [4:0]  slot;
        logic [3:0]  tick;
        logic        half;
        logic [8:0]  cmd;
        logic [15:0] sh;
        logic [1:0]  sync;
        logic        sk;
        logic        cs;
        logic        di;
        logic        done;
        logic [15:0] word;
    } scl_rd_s;

    scl_rd_s q_ff;
    scl_rd_s nxt_q;

    // ------------------------------------------------------------
    // command out, sixteen bits in, msb first
    // ------------------------------------------------------------
    always_comb begin
        nxt_q      = q_ff;
        nxt_q.sync = {q_ff.sync[0], ee_data_in_i};
        nxt_q.done = 1'b0;
        case (q_ff.st)
            RD_IDLE: begin
                if (rd.req) begin
                    nxt_q.st   = RD_SHIFT;
                    nxt_q.cs   = 1'b1;
                    nxt_q.cmd  = {RD_OPCODE, rd.addr[ADDR_W-1:0]};
                    nxt_q.di   = RD_OPCODE[2];
                    nxt_q.slot = 5'h00;
                    nxt_q.tick = 4'h0;
                    nxt_q.half = 1'b0;
                    nxt_q.sk   = 1'b0;
                end
            end
            RD_SHIFT: begin
                nxt_q.tick = q_ff.tick + 4'h1;
                if (q_ff.tick == TICK_LAST) begin
                    nxt_q.tick = 4'h0;
                    if (!q_ff.half) begin
                        nxt_q.half = 1'b1;
                        nxt_q.sk   = 1'b1;
                    end else begin
                        nxt_q.half = 1'b0;
                        nxt_q.sk   = 1'b0;
                        if (q_ff.slot >= SLOT_DATA0) begin
                            nxt_q.sh = {q_ff.sh[14:0], q_ff.sync[1]};
                        end
                        if (q_ff.slot == SLOT_LAST) begin
                            nxt_q.st   = RD_GAP;
                            nxt_q.cs   = 1'b0;
                            nxt_q.di   = 1'b0;
                            nxt_q.word = {q_ff.sh[14:0], q_ff.sync[1]};
                        end else begin
                            nxt_q.slot = q_ff.slot + 5'h01;
                            nxt_q.cmd  = {q_ff.cmd[7:0], 1'b0};
                            nxt_q.di   = q_ff.cmd[7];
                        end
                    end
                end
            end
            RD_GAP: begin
                // chip select low for one full bit time between words
                nxt_q.tick = q_ff.tick + 4'h1;
                if (q_ff.tick == TICK_LAST) begin
                    nxt_q.tick = 4'h0;
                    nxt_q.half = ~q_ff.half;
                    if (q_ff.half) begin
                        nxt_q.st   = RD_IDLE;
                        nxt_q.done = 1'b1;
                    end
                end
            end
            default: begin
                nxt_q.st = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign ee_clk_o      = q_ff.sk;
    assign ee_sel_o      = q_ff.cs;
    assign ee_data_out_o = q_ff.di;
    assign rd.busy       = (q_ff.st != RD_IDLE);
    assign rd.done       = q_ff.done;
    assign rd.word       = q_ff.word;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_clk_under_select: assert property (
        $rose(q_ff.sk) |-> q_ff.cs)
        else $error("serial clock rose without chip select");

    chk_word_length: assert property (
        (q_ff.st == RD_IDLE && rd.req) |-> ##[500:540] q_ff.done)
        else $error("word read did not complete in its bit count");

endmodule
`default_nettype wire

// ### rtl/scl_loader.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - image is 16-bit words, read one by one
// - reload request reruns the whole load
// - signature match sets valid-image flag
// - header bits 2..0 flag zones 1..3
// - present zones read in order, absent skipped
// - zone 1 word: more, offset, byte
// - zone 1 last word moves to next zone
// - zone 1 offset is local register byte
// - offset 0x00 loads control byte, low bits zero
// - offsets 0x04..0x0d load io and timing
// - offsets 0x0e..0x0f load timing two, zero fields
// - offsets 0x1e..0x1f load interrupt masks
// - zone 2 selectors 0..3 load identifiers
// - zone 2 last word moves to next zone
// - load starts right after reset, ends cleanly
// - no memory present leaves defaults untouched
// - zone 3 framed by 0x8001 and any end word
// - zone 3 word writes one config byte
module scl_loader
    import scl_pkg::*;
(
    input  wire logic  core_clk_i,
    input  wire logic  reset_n_i,
    input  wire logic  reload_req_i,
    input  wire logic  ee_data_in_i,
    output logic       ee_clk_o,
    output logic       ee_sel_o,
    output logic       ee_data_out_o,
    output logic       cfg_wr_o,
    output logic [1:0] cfg_space_o,
    output logic [6:0] cfg_offset_o,
    output logic [7:0] cfg_data_o,
    output logic       image_valid_o,
    output logic       load_busy_o
);

    typedef struct packed {
        scl_ld_e     st;
        logic [2:0]  zone;
        logic [2:0]  flags;
        logic [1:0]  z3ph;
        logic [7:0]  addr;
        logic [15:0] word;
        logic        valid;
        logic        wr;
        logic [1:0]  space;
        logic [6:0]  off;
        logic [7:0]  data;
    } scl_ld_s;

    scl_ld_s    q_ff;
    scl_ld_s    nxt_q;
    logic [2:0] nxt_zone;
    logic       rst_meta_ff;
    logic       rst_sync_ff;
    logic       rst_n;

    scl_rd_if rd_bus ();

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // ------------------------------------------------------------
    // serial word reader
    // ------------------------------------------------------------
    scl_word_rd u_word_rd (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n),
        .ee_data_in_i  (ee_data_in_i),
        .ee_clk_o      (ee_clk_o),
        .ee_sel_o      (ee_sel_o),
        .ee_data_out_o (ee_data_out_o),
        .rd            (rd_bus.reader)
    );

    assign rd_bus.req  = (q_ff.st == LD_REQ);
    assign rd_bus.addr = q_ff.addr;

    // ------------------------------------------------------------
    // zone walker
    // ------------------------------------------------------------
    always_comb begin
        nxt_q    = q_ff;
        nxt_zone = q_ff.zone;
        nxt_q.wr = 1'b0;
        case (q_ff.st)
            LD_REQ: begin
                // reader takes the request in the cycle it is idle
                if (!rd_bus.busy) begin
                    nxt_q.st = LD_WAIT;
                end
            end
            LD_WAIT: begin
                if (rd_bus.done) begin
                    nxt_q.st   = LD_DECODE;
                    nxt_q.word = rd_bus.word;
                end
            end
            LD_DECODE: begin
                nxt_q.st    = LD_REQ;
                nxt_q.addr  = q_ff.addr + 8'h01;
                nxt_q.off   = q_ff.word[14:8];
                nxt_q.data  = q_ff.word[7:0];
                case (q_ff.zone)
                    ZONE_HDR: begin
                        if (q_ff.word[15:HDR_SIG_LSB] == HDR_SIG) begin
                            nxt_q.valid = 1'b1;
                            nxt_q.flags = q_ff.word[2:0];
                            nxt_zone = scl_next_zone(ZONE_HDR,
                                                     q_ff.word[2:0]);
                        end else begin
                            nxt_zone = ZONE_END;
                        end
                    end
                    ZONE_LOCAL: begin
                        nxt_q.wr    = 1'b1;
                        nxt_q.space = SPACE_LOCAL;
                        nxt_q.data  = scl_mask_byte(q_ff.word[14:8],
                                                    q_ff.word[7:0]);
                        if (!q_ff.word[MORE_BIT]) begin
                            nxt_zone = scl_next_zone(q_ff.zone,
                                                     q_ff.flags);
                        end
                    end
                    ZONE_ID: begin
                        // reserved selectors are consumed, not written
                        nxt_q.wr    = (q_ff.word[14:8] <= ID_SEL_LAST);
                        nxt_q.space = SPACE_ID;
                        if (!q_ff.word[MORE_BIT]) begin
                            nxt_zone = scl_next_zone(q_ff.zone,
                                                     q_ff.flags);
                        end
                    end
                    ZONE_PCI: begin
                        case (q_ff.z3ph)
                            Z3_PH_HDR: begin
                                if (q_ff.word == Z3_HDR_WORD) begin
                                    nxt_q.z3ph = Z3_PH_DATA;
                                end else begin
                                    nxt_zone = ZONE_END;
                                end
                            end
                            Z3_PH_DATA: begin
                                nxt_q.wr    = 1'b1;
                                nxt_q.space = SPACE_PCI;
                                if (!q_ff.word[MORE_BIT]) begin
                                    nxt_q.z3ph = Z3_PH_TAIL;
                                end
                            end
                            default: begin
                                // end word closes the last zone
                                nxt_zone = ZONE_END;
                            end
                        endcase
                    end
                    default: begin
                        nxt_zone = ZONE_END;
                    end
                endcase
                nxt_q.zone = nxt_zone;
                if (nxt_zone == ZONE_PCI && q_ff.zone != ZONE_PCI) begin
                    nxt_q.z3ph = Z3_PH_HDR;
                end
                // end of data or end of the memory ends the load
                if (nxt_zone == ZONE_END || q_ff.addr == ADDR_LAST) begin
                    nxt_q.st = LD_DONE;
                end
            end
            LD_DONE: begin
                nxt_q.st = LD_DONE;
            end
            default: begin
                nxt_q.st = LD_DONE;
            end
        endcase
        if (reload_req_i) begin
            nxt_q       = '0;
            nxt_q.st    = LD_REQ;
            nxt_q.zone  = ZONE_HDR;
        end
    end

    // reset state starts a load at once from word zero
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign cfg_wr_o      = q_ff.wr;
    assign cfg_space_o   = q_ff.space;
    assign cfg_offset_o  = q_ff.off;
    assign cfg_data_o    = q_ff.data;
    assign image_valid_o = q_ff.valid;
    assign load_busy_o   = (q_ff.st != LD_DONE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_hdr_seen;
        q_ff.st == LD_DECODE && q_ff.zone == ZONE_HDR;
    endsequence

    sequence s_hdr_good;
        s_hdr_seen ##0 (q_ff.word[15:HDR_SIG_LSB] == HDR_SIG);
    endsequence

    sequence s_local_last;
        q_ff.st == LD_DECODE && q_ff.zone == ZONE_LOCAL
            && !q_ff.word[MORE_BIT] && !reload_req_i;
    endsequence

    sequence s_id_last;
        q_ff.st == LD_DECODE && q_ff.zone == ZONE_ID
            && !q_ff.word[MORE_BIT] && !reload_req_i;
    endsequence

    sequence s_z3_frame_word;
        q_ff.st == LD_DECODE && q_ff.zone == ZONE_PCI
            && q_ff.z3ph != Z3_PH_DATA && !reload_req_i;
    endsequence

    chk_valid_on_match: assert property (
        (s_hdr_good ##0 !reload_req_i) |=> image_valid_o)
        else $error("valid flag not set after good header");

    chk_bad_hdr_stop: assert property (
        (s_hdr_seen ##0 !(q_ff.word[15:HDR_SIG_LSB] == HDR_SIG)
            ##0 !reload_req_i) |=> !load_busy_o && !image_valid_o)
        else $error("bad header did not stop the load");

    chk_write_needs_valid: assert property (
        cfg_wr_o |-> image_valid_o)
        else $error("register write without a valid image");

    chk_ctrl_low_bits: assert property (
        (cfg_wr_o && cfg_space_o == SPACE_LOCAL
            && cfg_offset_o == OFS_LOCAL_CONFIG_CONTROL)
            |-> cfg_data_o[1:0] == 2'b00)
        else $error("control byte low bits not zero");

    chk_reload_runs: assert property (
        reload_req_i |=> load_busy_o && !image_valid_o
            && q_ff.addr == 8'h00)
        else $error("reload did not restart at word zero");

    chk_zone_ascends: assert property (
        !$past(reload_req_i) |-> q_ff.zone >= $past(q_ff.zone))
        else $error("zone order went backwards");

    chk_local_leaves: assert property (
        s_local_last |=> q_ff.zone != ZONE_LOCAL)
        else $error("local zone not left on last word");

    chk_id_selector: assert property (
        (cfg_wr_o && cfg_space_o == SPACE_ID)
            |-> cfg_offset_o <= ID_SEL_LAST)
        else $error("reserved identification selector written");

    chk_pci_framed: assert property (
        (cfg_wr_o && cfg_space_o == SPACE_PCI)
            |-> q_ff.zone == ZONE_PCI || !load_busy_o)
        else $error("config write outside the pci zone");

    chk_id_leaves: assert property (
        s_id_last |=> q_ff.zone != ZONE_ID)
        else $error("identification zone not left on last word");

    chk_frame_unwritten: assert property (
        s_z3_frame_word |=> !cfg_wr_o)
        else $error("zone three frame word was written");

    chk_z3_bad_hdr: assert property (
        (s_z3_frame_word ##0 (q_ff.z3ph == Z3_PH_HDR)
            ##0 (q_ff.word != Z3_HDR_WORD)) |=> !load_busy_o)
        else $error("bad zone three header did not end the load");

    chk_write_from_decode: assert property (
        cfg_wr_o |-> $past(q_ff.st) == LD_DECODE)
        else $error("register write without a decoded word");

    chk_done_quiet: assert property (
        (q_ff.st == LD_DONE && !reload_req_i)
            |=> !load_busy_o && !cfg_wr_o)
        else $error("finished load became active again");

endmodule
`default_nettype wire

// ### verification/scl_ee_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// serial memory holding the configuration image
// ------------------------------------------------------------
module scl_ee_model (
    input  wire logic ee_clk_i,
    input  wire logic ee_sel_i,
    input  wire logic ee_di_i,
    input  wire logic present_i,
    output logic      ee_do_o
);
    logic [15:0] mem [0:63];
    logic [8:0]  cmd;
    logic        last;
    int          cnt;

    initial begin
        cnt     = 0;
        cmd     = 9'h000;
        last    = 1'b0;
        ee_do_o = 1'b1;
    end

    // released line shows the inverse of the last bit; absent reads high
    always @(posedge ee_clk_i or negedge ee_sel_i) begin
        if (!ee_sel_i) begin
            cnt     = 0;
            ee_do_o = present_i ? ~last : 1'b1;
        end else begin
            if (cnt < 9) begin
                cmd = {cmd[7:0], ee_di_i};
            end else if (cnt < 25) begin
                // only a read opcode gets data, msb first
                last = (present_i && cmd[8:6] == 3'h6) ?
                       mem[cmd[5:0]][24 - cnt] : 1'b1;
                ee_do_o = last;
            end
            cnt = cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ### verification/scl_loader_test.sv
`timescale 1ns/1ns
`default_nettype none
module scl_loader_test;
    import scl_pkg::*;
    logic        core_clk_i;
    logic        reset_n_i;
    logic        reload_req_i;
    logic        present;
    logic        ee_din;
    logic        ee_clk;
    logic        ee_sel;
    logic        ee_dout;
    logic        cfg_wr;
    logic [1:0]  space;
    logic [6:0]  ofs;
    logic [7:0]  dat;
    logic        valid;
    logic        busy;
    int          fail_count;
    int          n_compared;
    logic [16:0] got_q[$];
    logic [16:0] exp_q[$];
    logic [15:0] img_q[$];

    scl_loader i_dut (
        .core_clk_i    (core_clk_i),
        .reset_n_i     (reset_n_i),
        .reload_req_i  (reload_req_i),
        .ee_data_in_i  (ee_din),
        .ee_clk_o      (ee_clk),
        .ee_sel_o      (ee_sel),
        .ee_data_out_o (ee_dout),
        .cfg_wr_o      (cfg_wr),
        .cfg_space_o   (space),
        .cfg_offset_o  (ofs),
        .cfg_data_o    (dat),
        .image_valid_o (valid),
        .load_busy_o   (busy)
    );

    scl_ee_model i_mem (
        .ee_clk_i  (ee_clk),
        .ee_sel_i  (ee_sel),
        .ee_di_i   (ee_dout),
        .present_i (present),
        .ee_do_o   (ee_din)
    );

    // ------------------------------------------------------------
    // clock, write capture and checking
    // ------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (cfg_wr === 1'b1) begin
            got_q.push_back({space, ofs, dat});
        end
    end

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // one load: image in, optional reload pulse, compare writes
    // ------------------------------------------------------------
    task automatic do_test(input string nm, input logic rl,
                           input logic vexp);
        int n;
        for (int i = 0; i < 64; i++) begin
            i_mem.mem[i] = (i < img_q.size()) ? img_q[i] : 16'h0000;
        end
        got_q.delete();
        @(posedge core_clk_i);
        #1;
        if (rl) begin
            reload_req_i = 1'b1;
            @(posedge core_clk_i);
            #1;
            reload_req_i = 1'b0;
        end else begin
            reset_n_i = 1'b1;
        end
        repeat (6) @(posedge core_clk_i);
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 20000) begin
            $display("BAD t=%0t load did not finish", $time);
            fail_count++;
        end
        #1;
        for (int i = 0; i < exp_q.size(); i++) begin
            check((i < got_q.size()) ? got_q[i] : {17{1'bx}},
                  exp_q[i]);
        end
        check(17'(got_q.size()), 17'(exp_q.size()));
        check({16'h0000, valid}, {16'h0000, vexp});
        check({15'h0000, ee_clk, ee_sel}, 17'h00000);
        $display("test %s done", nm);
    endtask

    initial begin
        reset_n_i    = 1'b0;
        reload_req_i = 1'b0;
        present      = 1'b1;
        fail_count   = 0;
        n_compared   = 0;
        repeat (8) @(posedge core_clk_i);
        // all zones, must-be-zero masking, reserved id selector
        img_q = '{16'h5a37, 16'h80ff, 16'h8eff, 16'h0fff, 16'h8312,
                  16'h8455, 16'h0034, 16'h8001, 16'h82cd, 16'h03ab,
                  16'h0000};
        exp_q = '{{2'h1, 7'h00, 8'hfc}, {2'h1, 7'h0e, 8'hf0},
                  {2'h1, 7'h0f, 8'hdf}, {2'h2, 7'h03, 8'h12},
                  {2'h2, 7'h00, 8'h34}, {2'h3, 7'h02, 8'hcd},
                  {2'h3, 7'h03, 8'hab}};
        do_test("all_zones", 1'b0, 1'b1);
        // zones 1 and 3 only, started by the reload request
        img_q = '{16'h5a35, 16'h8455, 16'h8d77, 16'h1ea5, 16'h8001,
                  16'h0610, 16'h0000};
        exp_q = '{{2'h1, 7'h04, 8'h55}, {2'h1, 7'h0d, 8'h77},
                  {2'h1, 7'h1e, 8'ha5}, {2'h3, 7'h06, 8'h10}};
        do_test("skip_zone", 1'b1, 1'b1);
        // zone 2 alone, ended by a cleared more flag
        img_q = '{16'h5a32, 16'h8101, 16'h0202, 16'h0303};
        exp_q = '{{2'h2, 7'h01, 8'h01}, {2'h2, 7'h02, 8'h02}};
        do_test("id_only", 1'b1, 1'b1);
        // header with no zones
        img_q = '{16'h5a30, 16'h0004};
        exp_q.delete();
        do_test("hdr_only", 1'b1, 1'b1);
        // zone 3 with a wrong function header word
        img_q = '{16'h5a31, 16'h8002, 16'h0610};
        do_test("z3_bad_hdr", 1'b1, 1'b1);
        // wrong signature
        img_q = '{16'h5a47, 16'h0004, 16'h0111};
        do_test("bad_sig", 1'b1, 1'b0);
        // no memory fitted
        present = 1'b0;
        do_test("absent", 1'b1, 1'b0);
        stop_test();
    end

    initial begin
        #200000;
        $display("BAD t=%0t watchdog expired", $time);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
